//--- hdl/address_generator.sv
// Summary of operation
// RULE_01: General three-operand ops take base from a register directly; operand two register/memory/5-bit literal. The code also accepts 10-bit literals.
// RULE_02: Post-modified indirect uses the pointer as address, then steps the pointer.
// RULE_03: Pre-modified indirect adds a signed step first and uses the updated pointer.
// RULE_04: Register-indexed address is pointer plus offset register.
// RULE_05: Literal-offset address is pointer plus the instruction literal.
// RULE_06: Move source and destination may differ in mode but share one offset register.
// RULE_07: Move and accumulator ops add indexed, literal-offset modes and 8/16-bit literals.
// RULE_08: Multiply-accumulate pointers are 8 to 11; 8,9 read X, 10,11 read Y.
// RULE_09: Multiply-accumulate indexed mode only on pointer 9 for X and 11 for Y.
// RULE_10: Multiply-accumulate allows plain indirect, indexed, and post-step by 2, 4 or 6.
// RULE_11: Branch field is a signed 16-bit literal; interrupt-disable count is unsigned 14-bit.
// RULE_12: One circular buffer in X space, also for program pointers, and one in Y.
// RULE_13: Power-of-two buffers check both bounds; others check one direction only.
// RULE_14: Each buffer is bounded by 16-bit start and end, length up to 32K words.
// RULE_15: Y circular addresses are word addresses with the low bit cleared.
// RULE_16: Select value 15 turns circular addressing off for that space.
// RULE_17: X circular addressing needs X select not 15 and X enable bit 15 set.
// RULE_18: Y circular addressing needs Y select not 15 and Y enable bit 14 set.
// RULE_19: Upward steps check beyond the end, downward steps beyond the start.
// RULE_20: Corrected pointer is written back only in pre- or post-modified modes.
// RULE_21: Bit-reversed addressing only in the X unit and only for data writes.
// RULE_22: In bit-reversed mode only the modifier is taken in reversed bit order.
// RULE_23: Overshoot past an end wraps to the other end carrying the overshoot.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module address_generator
	import agen_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clock_en,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic req_valid,
	input wire class_t req_class,
	input wire unit_t req_unit,
	input wire mode_t req_mode,
	input wire logic req_word,
	input wire logic [3:0] req_pointer_index,
	input wire logic [15:0] req_pointer_value,
	input wire logic [15:0] req_offset_value,
	input wire logic [15:0] req_modifier,
	input wire logic [15:0] req_literal,
	input wire lit_kind_t req_lit_kind,
	input wire logic [3:0] req_base_index,
	output logic [15:0] ea,
	output logic ea_valid,
	output unit_t ea_unit,
	output logic ea_wrapped,
	output logic ptr_wb_en,
	output logic [3:0] ptr_wb_index,
	output logic [15:0] ptr_wb_value,
	output logic [15:0] literal_value,
	output logic literal_valid,
	output logic [3:0] base_operand_register,
	output logic base_valid,
	output logic fault
);

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] x_start;
		logic [15:0] x_end;
		logic [15:0] y_start;
		logic [15:0] y_end;
		logic [15:0] reverse;
		logic [15:0] last_ea;
		logic [15:0] rdata;
		logic [15:0] ea;
		logic ea_valid;
		unit_t unit;
		logic wrapped;
		logic wb_en;
		logic [3:0] wb_index;
		logic [15:0] wb_value;
		logic [15:0] lit_value;
		logic lit_valid;
		logic [3:0] base_reg;
		logic base_valid;
		logic fault;
	} state_t;

	state_t st_reg;
	state_t st_next;

	function automatic logic pointer_selected(input logic [3:0] sel, input logic [3:0] idx);
		return (sel != SEL_OFF) && (sel == idx); // RULE_16
	endfunction

	function automatic logic [15:0] extend_literal(input lit_kind_t kind, input logic [15:0] raw);
		unique case (kind)
			LIT_5: return {11'h000, raw[4:0]};
			LIT_8: return {8'h00, raw[7:0]};
			LIT_10: return {6'h00, raw[9:0]};
			LIT_DISABLE: return {2'h0, raw[13:0]}; // RULE_11
			LIT_BRANCH: return raw; // RULE_11
			LIT_16: return raw;
			default: return raw;
		endcase
	endfunction

	function automatic logic [14:0] bit_rev15(input logic [14:0] v);
		logic [14:0] r;
		r = 15'h0000;
		for (int i = 0; i < 15; i++) begin
			r[i] = v[14 - i];
		end
		return r;
	endfunction

	// Address path, kept apart from the state copy so the wrap units sit between the two.
	unit_t unit;
	logic [15:0] step;
	logic step_down;
	logic [15:0] sum;
	logic [15:0] magnitude;
	logic legal;
	logic rev_active;
	logic [15:0] rev_next;
	logic [1:0] mod_on;
	logic [15:0] check_addr;

	always_comb begin
		unit = req_unit;
		if (req_class == CLASS_MAC && req_unit != UNIT_X_WRITE) begin
			unit = (req_pointer_index <= MAC_X_LAST) ? UNIT_X_READ : UNIT_Y; // RULE_08
		end
		unique case (req_mode)
			MODE_POST, MODE_PRE: step = req_modifier;
			MODE_INDEXED: step = req_offset_value; // RULE_06
			MODE_LIT_OFFSET: step = req_literal;
			default: step = 16'h0000;
		endcase
		step_down = step[15];
		sum = req_pointer_value + step; // RULE_04 RULE_05
		magnitude = step_down ? (16'h0000 - step) : step;
		legal = 1'b0;
		unique case (req_class)
			CLASS_GENERAL: begin
				// Operand two only; the base operand is always a plain register.
				legal = (req_mode inside {MODE_DIRECT, MODE_INDIRECT, MODE_POST, MODE_PRE}) ||
					(req_mode == MODE_LITERAL && req_lit_kind inside {LIT_5, LIT_10}); // RULE_01
			end
			CLASS_MOVE: begin
				legal = (req_mode != MODE_LITERAL) ||
					(req_lit_kind inside {LIT_5, LIT_8, LIT_10, LIT_16}); // RULE_07
			end
			CLASS_MAC: begin
				legal = (req_pointer_index >= MAC_PTR_FIRST) &&
					(req_pointer_index <= MAC_PTR_LAST); // RULE_08
				unique case (req_mode)
					MODE_INDIRECT: ; // RULE_10
					MODE_POST: legal = legal &&
						(magnitude inside {MAC_STEP_2, MAC_STEP_4, MAC_STEP_6}); // RULE_10
					MODE_INDEXED: legal = legal && (req_pointer_index == MAC_X_INDEXED ||
						req_pointer_index == MAC_Y_INDEXED); // RULE_09
					default: legal = 1'b0; // RULE_10
				endcase
			end
			CLASS_OTHER: begin
				legal = (req_mode == MODE_DIRECT) || (req_mode == MODE_LITERAL);
			end
		endcase
		// Bit reversal takes priority over the X circular buffer on the write side.
		rev_active = (unit == UNIT_X_WRITE) && req_word && !step_down &&
			(req_mode == MODE_POST || req_mode == MODE_PRE) &&
			st_reg.reverse[REV_EN_BIT] &&
			pointer_selected(st_reg.ctrl[R_SEL_LSB +: 4], req_pointer_index); // RULE_21
		// Reverse-carry add: the pivot is a word modifier; the pointer keeps normal order.
		rev_next = {bit_rev15(bit_rev15(req_pointer_value[15:1]) +
			bit_rev15(st_reg.reverse[14:0])), 1'b0}; // RULE_22
		mod_on[0] = (unit != UNIT_Y) && !rev_active && st_reg.ctrl[X_EN_BIT] &&
			pointer_selected(st_reg.ctrl[X_SEL_LSB +: 4], req_pointer_index); // RULE_17 RULE_12
		mod_on[1] = (unit == UNIT_Y) && st_reg.ctrl[Y_EN_BIT] &&
			pointer_selected(st_reg.ctrl[Y_SEL_LSB +: 4], req_pointer_index); // RULE_18 RULE_12
		check_addr = (req_mode == MODE_INDIRECT) ? req_pointer_value : sum;
	end

	circ_if cb [2] ();

	for (genvar g = 0; g < 2; g++) begin : g_space
		assign cb[g].active = mod_on[g];
		assign cb[g].up = !step_down;
		assign cb[g].one_way_up = st_reg.ctrl[(g == 0) ? X_UP_BIT : Y_UP_BIT];
		assign cb[g].start = (g == 0) ? st_reg.x_start : st_reg.y_start;
		assign cb[g].stop = (g == 0) ? st_reg.x_end : st_reg.y_end;
		assign cb[g].addr_in = check_addr;
		circular_wrap u_wrap (
			.cb(cb[g])
		);
	end

	logic [15:0] corrected;
	logic [15:0] next_ptr;
	logic [15:0] new_ea;
	logic did_wrap;

	always_comb begin
		corrected = (unit == UNIT_Y) ? cb[1].addr_out : cb[0].addr_out;
		did_wrap = (unit == UNIT_Y) ? cb[1].wrapped : cb[0].wrapped;
		if (mod_on[1]) begin
			corrected[0] = 1'b0; // RULE_15
		end
		next_ptr = rev_active ? rev_next : corrected;
		unique case (req_mode)
			MODE_POST: new_ea = req_pointer_value; // RULE_02
			MODE_PRE: new_ea = next_ptr; // RULE_03
			MODE_INDEXED, MODE_LIT_OFFSET: new_ea = corrected; // RULE_04 RULE_05
			default: new_ea = corrected;
		endcase
		if (rev_active || mod_on[1]) begin
			new_ea[0] = 1'b0;
		end

		st_next = st_reg;
		st_next.ea_valid = 1'b0;
		st_next.wb_en = 1'b0;
		st_next.lit_valid = 1'b0;
		st_next.base_valid = 1'b0;
		st_next.fault = 1'b0;
		st_next.wrapped = 1'b0;

		if (reg_write) begin
			unique case (reg_addr)
				REG_CONTROL: st_next.ctrl = reg_wdata;
				REG_X_START: st_next.x_start = reg_wdata;
				REG_X_END: st_next.x_end = reg_wdata;
				REG_Y_START: st_next.y_start = reg_wdata;
				REG_Y_END: st_next.y_end = reg_wdata;
				REG_REVERSE: st_next.reverse = reg_wdata;
				default: ;
			endcase
		end
		st_next.rdata = 16'h0000;
		if (reg_read) begin
			unique case (reg_addr)
				REG_CONTROL: st_next.rdata = st_reg.ctrl;
				REG_X_START: st_next.rdata = st_reg.x_start;
				REG_X_END: st_next.rdata = st_reg.x_end;
				REG_Y_START: st_next.rdata = st_reg.y_start;
				REG_Y_END: st_next.rdata = st_reg.y_end;
				REG_REVERSE: st_next.rdata = st_reg.reverse;
				REG_LAST_EA: st_next.rdata = st_reg.last_ea;
				default: st_next.rdata = 16'h0000;
			endcase
		end

		if (req_valid) begin
			st_next.unit = unit;
			if (!legal) begin
				st_next.fault = 1'b1;
			end else begin
				if (req_class == CLASS_GENERAL) begin
					st_next.base_reg = req_base_index; // RULE_01
					st_next.base_valid = 1'b1;
				end
				if (req_mode == MODE_LITERAL) begin
					st_next.lit_value = extend_literal(req_lit_kind, req_literal); // RULE_11
					st_next.lit_valid = 1'b1;
				end else if (req_mode != MODE_DIRECT) begin
					st_next.ea = new_ea;
					st_next.ea_valid = 1'b1;
					st_next.last_ea = new_ea;
					st_next.wrapped = did_wrap;
				end
				// Offset modes correct the access only and leave the pointer alone.
				if (req_mode == MODE_POST || req_mode == MODE_PRE) begin
					st_next.wb_en = 1'b1; // RULE_20
					st_next.wb_index = req_pointer_index;
					st_next.wb_value = next_ptr; // RULE_20 RULE_02 RULE_03
				end
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.ctrl <= CONTROL_RESET;
			st_reg.x_start <= ADDR_RESET;
			st_reg.x_end <= ADDR_RESET;
			st_reg.y_start <= ADDR_RESET;
			st_reg.y_end <= ADDR_RESET;
			st_reg.unit <= UNIT_X_READ;
		end else if (clock_en) begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign ea = st_reg.ea;
	assign ea_valid = st_reg.ea_valid;
	assign ea_unit = st_reg.unit;
	assign ea_wrapped = st_reg.wrapped;
	assign ptr_wb_en = st_reg.wb_en;
	assign ptr_wb_index = st_reg.wb_index;
	assign ptr_wb_value = st_reg.wb_value;
	assign literal_value = st_reg.lit_value;
	assign literal_valid = st_reg.lit_valid;
	assign base_operand_register = st_reg.base_reg;
	assign base_valid = st_reg.base_valid;
	assign fault = st_reg.fault;

endmodule
`default_nettype wire

//--- hdl/agen_pkg.sv
package agen_pkg;

	// Register indices on the plain register port.
	localparam logic [2:0] REG_CONTROL = 3'h0;
	localparam logic [2:0] REG_X_START = 3'h1;
	localparam logic [2:0] REG_X_END = 3'h2;
	localparam logic [2:0] REG_Y_START = 3'h3;
	localparam logic [2:0] REG_Y_END = 3'h4;
	localparam logic [2:0] REG_REVERSE = 3'h5;
	localparam logic [2:0] REG_LAST_EA = 3'h6;

	// Fields of circular_buffer_control; REV_EN_BIT is a bit of the reverse register.
	localparam int X_SEL_LSB = 0;
	localparam int Y_SEL_LSB = 4;
	localparam int R_SEL_LSB = 8;
	localparam int X_UP_BIT = 12;
	localparam int Y_UP_BIT = 13;
	localparam int Y_EN_BIT = 14;
	localparam int X_EN_BIT = 15;
	localparam int REV_EN_BIT = 15;

	localparam logic [3:0] SEL_OFF = 4'hf;
	localparam logic [15:0] CONTROL_RESET = 16'h3fff;
	localparam logic [15:0] ADDR_RESET = 16'h0000;

	// Multiply-accumulate prefetch pointer set and its legal steps.
	localparam logic [3:0] MAC_PTR_FIRST = 4'h8;
	localparam logic [3:0] MAC_X_LAST = 4'h9;
	localparam logic [3:0] MAC_PTR_LAST = 4'hb;
	localparam logic [3:0] MAC_X_INDEXED = 4'h9;
	localparam logic [3:0] MAC_Y_INDEXED = 4'hb;
	localparam logic [15:0] MAC_STEP_2 = 16'h0002;
	localparam logic [15:0] MAC_STEP_4 = 16'h0004;
	localparam logic [15:0] MAC_STEP_6 = 16'h0006;

	typedef enum logic [2:0] {
		MODE_DIRECT, MODE_INDIRECT, MODE_POST, MODE_PRE,
		MODE_INDEXED, MODE_LIT_OFFSET, MODE_LITERAL
	} mode_t;
	typedef enum logic [1:0] {UNIT_X_READ, UNIT_X_WRITE, UNIT_Y} unit_t;
	typedef enum logic [1:0] {CLASS_GENERAL, CLASS_MOVE, CLASS_MAC, CLASS_OTHER} class_t;
	typedef enum logic [2:0] {
		LIT_5, LIT_8, LIT_10, LIT_16, LIT_BRANCH, LIT_DISABLE
	} lit_kind_t;

endpackage

//--- hdl/circ_if.sv
`timescale 1ns/1ps
`default_nettype none
interface circ_if;
	logic active;
	logic up;
	logic one_way_up;
	logic [15:0] start;
	logic [15:0] stop;
	logic [15:0] addr_in;
	logic [15:0] addr_out;
	logic wrapped;
	modport user(output active, up, one_way_up, start, stop, addr_in, input addr_out, wrapped);
	modport wrap(input active, up, one_way_up, start, stop, addr_in, output addr_out, wrapped);
endinterface
`default_nettype wire

//--- hdl/circular_wrap.sv
`timescale 1ns/1ps
`default_nettype none
module circular_wrap
	import agen_pkg::*;
(
	circ_if.wrap cb
);
	logic [15:0] span;
	logic pow2;
	logic check_up;
	logic check_dn;
	logic over;
	logic under;

	always_comb begin
		// A full 64 KB buffer gives a span of zero, which still counts as a power of two.
		span = cb.stop - cb.start + 16'h0001; // RULE_14
		pow2 = (span & (span - 16'h0001)) == 16'h0000;
		check_up = cb.up && (pow2 || cb.one_way_up); // RULE_13
		check_dn = !cb.up && (pow2 || !cb.one_way_up); // RULE_13
		over = check_up && (cb.addr_in > cb.stop); // RULE_19
		under = check_dn && (cb.addr_in < cb.start); // RULE_19
		cb.wrapped = cb.active && (over || under);
		cb.addr_out = cb.addr_in;
		// The overshoot is carried into the wrapped address, so one wrap per step is assumed.
		if (cb.active && over) begin
			cb.addr_out = cb.start + (cb.addr_in - cb.stop - 16'h0001); // RULE_23
		end else if (cb.active && under) begin
			cb.addr_out = cb.stop - (cb.start - cb.addr_in - 16'h0001); // RULE_23
		end
	end
endmodule
`default_nettype wire

//--- verification/address_generator_sva.sv
`timescale 1ns/1ps
`default_nettype none
module address_generator_sva
	import agen_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clock_en,
	input wire logic req_valid,
	input wire class_t req_class,
	input wire mode_t req_mode,
	input wire logic [3:0] req_pointer_index,
	input wire logic [15:0] req_modifier,
	input wire logic [15:0] req_literal,
	input wire lit_kind_t req_lit_kind,
	input wire logic [3:0] req_base_index,
	input wire logic [15:0] ea,
	input wire logic ptr_wb_en,
	input wire logic [3:0] ptr_wb_index,
	input wire logic [15:0] ptr_wb_value,
	input wire logic [15:0] literal_value,
	input wire logic literal_valid,
	input wire logic [3:0] base_operand_register,
	input wire logic base_valid,
	input wire logic fault
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence req_s;
		clock_en && req_valid;
	endsequence
	sequence pre_s;
		req_s ##0 req_mode == MODE_PRE;
	endsequence
	sequence mac_s;
		req_s ##0 req_class == CLASS_MAC;
	endsequence
	AST_WB_ONLY_MODIFY: assert property (req_s ##0 !(req_mode inside {MODE_POST, MODE_PRE})
		|=> !ptr_wb_en) else $error("pointer written back outside modify modes");
	AST_PRE_EA_IS_WB: assert property (pre_s ##1 ptr_wb_en |-> ea == ptr_wb_value)
		else $error("pre-modify address differs from new pointer");
	AST_WB_INDEX: assert property (req_s ##1 ptr_wb_en |-> ptr_wb_index == $past(req_pointer_index))
		else $error("write-back to wrong pointer");
	AST_MAC_PTR: assert property (mac_s ##0 (req_pointer_index < MAC_PTR_FIRST
		|| req_pointer_index > MAC_PTR_LAST) |=> fault) else $error("bad prefetch pointer taken");
	AST_MAC_INDEXED: assert property (mac_s ##0 (req_mode == MODE_INDEXED
		&& req_pointer_index != MAC_X_INDEXED && req_pointer_index != MAC_Y_INDEXED) |=> fault)
		else $error("indexed prefetch on wrong pointer");
	AST_MAC_STEP: assert property (mac_s ##0 (req_mode == MODE_POST && !(req_modifier inside
		{16'h0002, 16'h0004, 16'h0006, 16'hfffe, 16'hfffc, 16'hfffa})) |=> fault && !ptr_wb_en)
		else $error("bad prefetch step taken");
	AST_BASE: assert property (req_s ##0 (req_class == CLASS_GENERAL && req_mode == MODE_DIRECT)
		|=> base_valid && base_operand_register == $past(req_base_index))
		else $error("base register not reported");
	AST_DISABLE_LIT: assert property (req_s ##0 (req_class == CLASS_OTHER
		&& req_mode == MODE_LITERAL && req_lit_kind == LIT_DISABLE) |=> literal_valid
		&& literal_value == ($past(req_literal) & 16'h3fff)) else $error("count literal wrong");
endmodule
bind address_generator address_generator_sva chk_u (.clock, .sys_rst, .clock_en, .req_valid,
	.req_class, .req_mode, .req_pointer_index, .req_modifier, .req_literal, .req_lit_kind,
	.req_base_index, .ea, .ptr_wb_en, .ptr_wb_index, .ptr_wb_value, .literal_value,
	.literal_valid, .base_operand_register, .base_valid, .fault);
`default_nettype wire

//--- verification/address_generator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module address_generator_tb_top
	import agen_pkg::*;
;
	logic clock, sys_rst, clock_en, reg_write, reg_read, req_valid, req_word;
	logic [2:0] reg_addr;
	logic [3:0] req_pointer_index, req_base_index, ptr_wb_index, base_operand_register;
	logic [15:0] reg_wdata, reg_rdata, req_pointer_value, req_offset_value, req_modifier;
	logic [15:0] req_literal, ea, ptr_wb_value, literal_value;
	logic ea_valid, ea_wrapped, ptr_wb_en, literal_valid, base_valid, fault;
	class_t req_class;
	unit_t req_unit, ea_unit;
	mode_t req_mode;
	lit_kind_t req_lit_kind;
	int miscompares = 0;
	int num_checks = 0;
	address_generator dut_u (.clock, .sys_rst, .clock_en, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .req_valid, .req_class, .req_unit, .req_mode, .req_word,
		.req_pointer_index, .req_pointer_value, .req_offset_value, .req_modifier, .req_literal,
		.req_lit_kind, .req_base_index, .ea, .ea_valid, .ea_unit, .ea_wrapped, .ptr_wb_en,
		.ptr_wb_index, .ptr_wb_value, .literal_value, .literal_valid, .base_operand_register,
		.base_valid, .fault);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic cv(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cf(input logic got, input logic exp);
		cv({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 cv(reg_rdata, e);
	endtask
	task automatic rq(input class_t c, input unit_t u, input mode_t m, input logic [3:0] i,
		input logic [15:0] p, input logic [15:0] s, input logic [15:0] o);
		@(posedge clock);
		req_valid <= 1'b1;
		req_class <= c;
		req_unit <= u;
		req_mode <= m;
		req_pointer_index <= i;
		req_pointer_value <= p;
		req_modifier <= s;
		req_offset_value <= o;
		req_literal <= o;
		@(posedge clock);
		req_valid <= 1'b0;
		#1;
	endtask
	task automatic ck(input logic [15:0] e_ea, input logic wb, input logic [15:0] e_wb,
		input logic w);
		cf(fault, 1'b0);
		cf(ea_valid, 1'b1);
		cv(ea, e_ea);
		cf(ptr_wb_en, wb);
		if (wb) begin
			cv(ptr_wb_value, e_wb);
		end
		cf(ea_wrapped, w);
	endtask
	task automatic lit(input class_t c, input lit_kind_t k, input logic [15:0] l,
		input logic [15:0] e);
		@(posedge clock);
		req_lit_kind <= k;
		rq(c, UNIT_X_READ, MODE_LITERAL, 4'h0, 16'h0000, 16'h0000, l);
		cf(literal_valid, 1'b1);
		cv(literal_value, e);
	endtask
	task automatic t_regs();
		rd(REG_CONTROL, CONTROL_RESET);
		rd(REG_X_START, ADDR_RESET);
		wr(REG_LAST_EA, 16'hffff);
		rd(REG_LAST_EA, 16'h0000);
		rd(3'h7, 16'h0000);
		wr(REG_Y_END, 16'h1234);
		rd(REG_Y_END, 16'h1234);
		$display("t_regs done");
	endtask
	task automatic t_modes();
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_POST, 4'h1, 16'h1000, 16'h0002, 16'h0000);
		ck(16'h1000, 1'b1, 16'h1002, 1'b0);
		cv({12'h000, base_operand_register}, 16'h0005);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_PRE, 4'h1, 16'h1000, 16'hfffe, 16'h0000);
		ck(16'h0ffe, 1'b1, 16'h0ffe, 1'b0);
		rq(CLASS_MOVE, UNIT_X_WRITE, MODE_INDEXED, 4'h1, 16'h1000, 16'h0000, 16'h0010);
		ck(16'h1010, 1'b0, 16'h0000, 1'b0);
		rq(CLASS_MOVE, UNIT_X_READ, MODE_LIT_OFFSET, 4'h1, 16'h1000, 16'h0000, 16'h0020);
		ck(16'h1020, 1'b0, 16'h0000, 1'b0);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_INDEXED, 4'h1, 16'h1000, 16'h0000, 16'h0010);
		cf(fault, 1'b1);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_DIRECT, 4'h2, 16'h0000, 16'h0000, 16'h0000);
		cf(base_valid, 1'b1);
		$display("t_modes done");
	endtask
	task automatic t_lits();
		lit(CLASS_GENERAL, LIT_5, 16'hffff, 16'h001f);
		lit(CLASS_GENERAL, LIT_10, 16'hffff, 16'h03ff);
		lit(CLASS_MOVE, LIT_8, 16'hffff, 16'h00ff);
		lit(CLASS_MOVE, LIT_16, 16'hffff, 16'hffff);
		lit(CLASS_OTHER, LIT_BRANCH, 16'h8001, 16'h8001);
		lit(CLASS_OTHER, LIT_DISABLE, 16'hffff, 16'h3fff);
		@(posedge clock);
		req_lit_kind <= LIT_16;
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_LITERAL, 4'h0, 16'h0000, 16'h0000, 16'h0001);
		cf(literal_valid, 1'b0);
		$display("t_lits done");
	endtask
	task automatic t_mac();
		rq(CLASS_MAC, UNIT_X_READ, MODE_INDIRECT, 4'h8, 16'h0800, 16'h0000, 16'h0000);
		ck(16'h0800, 1'b0, 16'h0000, 1'b0);
		rq(CLASS_MAC, UNIT_X_READ, MODE_INDIRECT, 4'ha, 16'h0900, 16'h0000, 16'h0000);
		cv({14'h0000, ea_unit}, {14'h0000, UNIT_Y});
		rq(CLASS_MAC, UNIT_X_READ, MODE_INDIRECT, 4'hc, 16'h0900, 16'h0000, 16'h0000);
		cf(fault, 1'b1);
		rq(CLASS_MAC, UNIT_X_READ, MODE_INDEXED, 4'h8, 16'h0800, 16'h0000, 16'h0004);
		cf(fault, 1'b1);
		rq(CLASS_MAC, UNIT_Y, MODE_INDEXED, 4'hb, 16'h0900, 16'h0000, 16'h0004);
		ck(16'h0904, 1'b0, 16'h0000, 1'b0);
		for (int s = 2; s <= 6; s += 2) begin
			rq(CLASS_MAC, UNIT_Y, MODE_POST, 4'hb, 16'h0900, 16'(s), 16'h0000);
			ck(16'h0900, 1'b1, 16'h0900 + 16'(s), 1'b0);
		end
		rq(CLASS_MAC, UNIT_Y, MODE_POST, 4'hb, 16'h0900, 16'h0003, 16'h0000);
		cf(fault, 1'b1);
		$display("t_mac done");
	endtask
	task automatic t_circ();
		wr(REG_CONTROL, 16'hf432);
		wr(REG_X_START, 16'h1000);
		wr(REG_X_END, 16'h100f);
		wr(REG_Y_START, 16'h2000);
		wr(REG_Y_END, 16'h2007);
		wr(REG_REVERSE, 16'h8008);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_POST, 4'h2, 16'h100e, 16'h0004, 16'h0000);
		ck(16'h100e, 1'b1, 16'h1002, 1'b1);
		rq(CLASS_GENERAL, UNIT_X_WRITE, MODE_POST, 4'h2, 16'h1000, 16'hfffe, 16'h0000);
		ck(16'h1000, 1'b1, 16'h100e, 1'b1);
		rq(CLASS_MOVE, UNIT_X_READ, MODE_INDEXED, 4'h2, 16'h100c, 16'h0000, 16'h0006);
		ck(16'h1002, 1'b0, 16'h0000, 1'b1);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_POST, 4'h7, 16'h100e, 16'h0004, 16'h0000);
		ck(16'h100e, 1'b1, 16'h1012, 1'b0);
		rq(CLASS_GENERAL, UNIT_Y, MODE_INDIRECT, 4'h3, 16'h2003, 16'h0000, 16'h0000);
		ck(16'h2002, 1'b0, 16'h0000, 1'b0);
		rq(CLASS_GENERAL, UNIT_Y, MODE_POST, 4'h3, 16'h2006, 16'h0002, 16'h0000);
		ck(16'h2006, 1'b1, 16'h2000, 1'b1);
		rq(CLASS_GENERAL, UNIT_X_WRITE, MODE_POST, 4'h4, 16'h0010, 16'h0002, 16'h0000);
		ck(16'h0010, 1'b1, 16'h0008, 1'b0);
		@(posedge clock);
		req_word <= 1'b0;
		rq(CLASS_GENERAL, UNIT_X_WRITE, MODE_POST, 4'h4, 16'h0010, 16'h0002, 16'h0000);
		ck(16'h0010, 1'b1, 16'h0012, 1'b0);
		@(posedge clock);
		req_word <= 1'b1;
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_POST, 4'h4, 16'h0010, 16'h0002, 16'h0000);
		ck(16'h0010, 1'b1, 16'h0012, 1'b0);
		rd(REG_LAST_EA, 16'h0010);
		wr(REG_X_END, 16'h100b);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_POST, 4'h2, 16'h1000, 16'hfffe, 16'h0000);
		ck(16'h1000, 1'b1, 16'h0ffe, 1'b0);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_POST, 4'h2, 16'h100a, 16'h0004, 16'h0000);
		ck(16'h100a, 1'b1, 16'h1002, 1'b1);
		wr(REG_CONTROL, 16'h7432);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_POST, 4'h2, 16'h100e, 16'h0004, 16'h0000);
		ck(16'h100e, 1'b1, 16'h1012, 1'b0);
		wr(REG_CONTROL, 16'hf4ff);
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_POST, 4'hf, 16'h100e, 16'h0004, 16'h0000);
		ck(16'h100e, 1'b1, 16'h1012, 1'b0);
		rq(CLASS_GENERAL, UNIT_Y, MODE_POST, 4'hf, 16'h2006, 16'h0002, 16'h0000);
		ck(16'h2006, 1'b1, 16'h2008, 1'b0);
		$display("t_circ done");
	endtask
	// A request presented while the clock enable is low must leave every output as it was.
	task automatic t_hold();
		@(posedge clock);
		clock_en <= 1'b0;
		rq(CLASS_GENERAL, UNIT_X_READ, MODE_PRE, 4'h1, 16'h3000, 16'h0002, 16'h0000);
		cf(ea_valid, 1'b0);
		cv(ea, 16'h2006);
		cf(ptr_wb_en, 1'b0);
		@(posedge clock);
		clock_en <= 1'b1;
		$display("t_hold done");
	endtask
	task automatic t_reset();
		@(posedge clock);
		sys_rst <= 1'b1;
		@(posedge clock);
		sys_rst <= 1'b0;
		#1 cv(ea, 16'h0000);
		rd(REG_CONTROL, CONTROL_RESET);
		rd(REG_X_END, ADDR_RESET);
		$display("t_reset done");
	endtask
	// A hang anywhere still reaches the verdict.
	initial begin
		#1000000;
		miscompares++;
		complete_run();
	end
	initial begin
		sys_rst = 1'b1;
		clock_en = 1'b1;
		req_word = 1'b1;
		{reg_write, reg_read, req_valid} = 3'h0;
		reg_addr = 3'h0;
		{reg_wdata, req_pointer_value, req_modifier, req_offset_value, req_literal} = 80'h0;
		req_pointer_index = 4'h0;
		req_base_index = 4'h5;
		req_class = CLASS_GENERAL;
		req_unit = UNIT_X_READ;
		req_mode = MODE_DIRECT;
		req_lit_kind = LIT_5;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs();
		t_modes();
		t_lits();
		t_mac();
		t_circ();
		t_hold();
		t_reset();
		complete_run();
	end
endmodule
`default_nettype wire
